// File: design/isd_sda_path.sv
// serial-data path of an i2c channel: delayed sda drive, receive buffer
// arrangement, ack/nack events and start-condition reinitialisation
// assumes scl comes from the far side (external clock) and sda is
// open drain; configuration comes from logic on clock_in

module isd_sda_path (
  input  wire logic               clock_in,
  input  wire logic               reset_n_in,
  input  wire logic               scl_clk_in,
  input  wire logic               serial_data_pin_in,
  input  wire isd_pkg::isd_cfg_s  cfg_in,
  input  wire logic [8:0]         transmit_buffer_in,
  input  wire logic               transmit_buffer_write_in,
  input  wire logic               wait_clear_in,
  output logic                    serial_data_pin_out,
  output logic                    serial_data_pin_oe_out,
  output logic                    serial_clock_pin_out,
  output logic                    serial_clock_pin_oe_out,
  output logic [8:0]              receive_buffer_out,
  output isd_pkg::isd_evt_s       events_out,
  output logic                    transmit_buffer_empty_flag_out,
  output logic                    wait_after_eighth_bit_out
);

  // ----------------------------------------------------------------
  // link domain: sample sda on each scl rise
  // ----------------------------------------------------------------
  // data only, no reset: the scl clock may stand still during reset
  logic [8:0] link_shift;
  logic [8:0] next_link_shift;

  always_comb
  begin
    next_link_shift = {link_shift[7:0], serial_data_pin_in};
  end

  always_ff @(posedge scl_clk_in)
  begin
    link_shift <= next_link_shift;
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_m <= scl_clk_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= serial_data_pin_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  logic rise, fall, start;
  assign rise  = scl_s & ~scl_d;
  assign fall  = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;

  // ----------------------------------------------------------------
  // byte sequencing, transmit, receive, events
  // ----------------------------------------------------------------
  logic [3:0]        bit_count, next_bit_count;
  logic [8:0]        tx_shift, next_tx_shift;
  logic              tx_empty, next_tx_empty;
  logic              wait_after_eighth_bit, next_swc;
  logic              scl_hold, next_scl_hold;
  logic              pend_valid, next_pend_valid;
  logic              pend_level, next_pend_level;
  logic [3:0]        delay_cnt, next_delay_cnt;
  logic              sda_oe, next_sda_oe;
  logic [8:0]        rx_buf, next_rx_buf;
  isd_pkg::isd_evt_s evt, next_evt;

  logic [8:0] tx_order;
  logic [3:0] count_up;
  logic       new_bit;
  logic       plain;

  // transmit order b7..b0 then b8
  assign tx_order = {transmit_buffer_in[7:0], transmit_buffer_in[8]};
  assign count_up = bit_count + 4'h1;
  assign plain    = cfg_in.clock_phase_delay | ~cfg_in.rx_bit_arrangement_sel;

  always_comb
  begin
    next_bit_count  = bit_count;
    next_tx_shift   = tx_shift;
    next_tx_empty   = tx_empty;
    next_swc        = wait_after_eighth_bit;
    next_scl_hold   = scl_hold;
    next_pend_valid = pend_valid;
    next_pend_level = pend_level;
    next_delay_cnt  = delay_cnt;
    next_sda_oe     = sda_oe;
    next_rx_buf     = rx_buf;
    next_evt        = '0;
    new_bit         = 1'b1;

    // software clears first so that a hardware set in the same cycle wins
    if (transmit_buffer_write_in)
      next_tx_empty = 1'b0;
    if (wait_clear_in)
    begin
      next_swc      = 1'b0;
      next_scl_hold = 1'b0;
    end

    if (start)
    begin
      next_evt.start = 1'b1;
      next_bit_count = isd_pkg::SLOT_FIRST;
      if (cfg_in.start_detect_init_enable)
      begin
        next_tx_shift = tx_order;
        next_swc      = 1'b1;
      end
      else if (!tx_empty)
      begin
        next_tx_shift = tx_order;
        next_tx_empty = 1'b1;
      end
    end
    else if (rise && bit_count != isd_pkg::SLOT_ACK)
    begin
      // link_shift settled at the scl edge, two syncs before this read
      next_bit_count = count_up;
      if (count_up == isd_pkg::SLOT_DATA)
      begin
        if (cfg_in.clock_phase_delay)
        begin
          next_rx_buf    = {1'b0, link_shift[7:0]};
          next_evt.rx_update = 1'b1;
        end
        else if (cfg_in.rx_bit_arrangement_sel)
        begin
          next_rx_buf    = {link_shift[0], 1'b0, link_shift[7:1]};
          next_evt.rx_update = 1'b1;
        end
      end
      if (count_up == isd_pkg::SLOT_ACK)
      begin
        if (plain)
        begin
          next_rx_buf    = {link_shift[0], link_shift[8:1]};
          next_evt.rx_update = 1'b1;
        end
        if (!cfg_in.rx_bit_arrangement_sel)
        begin
          next_evt.ack  = ~link_shift[0];
          next_evt.nack = link_shift[0];
          next_evt.dma  = ~link_shift[0] & cfg_in.dma_on_rx_or_ack;
        end
      end
    end
    else if (fall)
    begin
      if (bit_count == isd_pkg::SLOT_ACK)
      begin
        next_bit_count = isd_pkg::SLOT_FIRST;
        if (wait_after_eighth_bit)
          next_scl_hold = 1'b1;
        if (!tx_empty)
        begin
          next_tx_shift = tx_order;
          next_tx_empty = 1'b1;
          new_bit       = tx_order[8];
        end
        else
        begin
          next_tx_shift = isd_pkg::TX_IDLE;
        end
      end
      else if (bit_count == isd_pkg::SLOT_FIRST)
      begin
        new_bit = tx_shift[8];
      end
      else
      begin
        // slots one to eight come from the buffer; 1ffh releases them
        next_tx_shift = {tx_shift[7:0], 1'b1};
        new_bit       = tx_shift[7];
      end
      next_pend_valid = 1'b1;
      if (cfg_in.ack_output_enable && !cfg_in.condition_generator_select)
        next_pend_level = cfg_in.ack_data_value;
      else
        next_pend_level = new_bit;
      if (cfg_in.sda_delay_select == isd_pkg::DELAY_OFF)
        next_delay_cnt = 4'h0;
      else
        next_delay_cnt = {1'b0, cfg_in.sda_delay_select} + isd_pkg::DELAY_EXTRA;
    end

    // the output may only move while scl is low
    if (pend_valid && !fall)
    begin
      // counting down to zero gives code n (n > 0) exactly n + 1 extra cycles
      if (delay_cnt != 4'h0)
        next_delay_cnt = delay_cnt - 4'h1;
      else if (!scl_s)
      begin
        next_sda_oe     = ~pend_level;
        next_pend_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      bit_count  <= isd_pkg::SLOT_FIRST;
      tx_shift   <= isd_pkg::TX_IDLE;
      tx_empty   <= 1'b1;
      wait_after_eighth_bit        <= 1'b0;
      scl_hold   <= 1'b0;
      pend_valid <= 1'b0;
      pend_level <= 1'b1;
      delay_cnt  <= 4'h0;
      sda_oe     <= 1'b0;
      rx_buf     <= isd_pkg::RB_RESET;
      evt        <= '0;
    end
    else
    begin
      bit_count  <= next_bit_count;
      tx_shift   <= next_tx_shift;
      tx_empty   <= next_tx_empty;
      wait_after_eighth_bit        <= next_swc;
      scl_hold   <= next_scl_hold;
      pend_valid <= next_pend_valid;
      pend_level <= next_pend_level;
      delay_cnt  <= next_delay_cnt;
      sda_oe     <= next_sda_oe;
      rx_buf     <= next_rx_buf;
      evt        <= next_evt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: the driven level is always low
  logic pin_low;

  always_ff @(posedge clock_in)
  begin
    pin_low <= 1'b0;
  end

  assign serial_data_pin_out            = pin_low;
  assign serial_clock_pin_out           = pin_low;
  assign serial_data_pin_oe_out         = sda_oe;
  assign serial_clock_pin_oe_out        = scl_hold;
  assign receive_buffer_out             = rx_buf;
  assign events_out                     = evt;
  assign transmit_buffer_empty_flag_out = tx_empty;
  assign wait_after_eighth_bit_out      = wait_after_eighth_bit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_sda_low_only;
    $changed(sda_oe) |-> !$past(scl_s);
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("sda moved while scl high");

  property p_delay_off;
    fall && cfg_in.sda_delay_select == 3'h0 ##1 !scl_s |=> !pend_valid;
  endproperty
  a_delay_off: assert property (p_delay_off) else $error("undelayed sda not applied");

  property p_delay_max;
    fall && cfg_in.sda_delay_select == 3'h7 |=> ##1 $stable(sda_oe)[*8];
  endproperty
  a_delay_max: assert property (p_delay_max) else $error("sda changed before full delay");

  property p_rx_plain;
    evt.rx_update && $past(bit_count) == 4'h8 && $past(plain)
      |-> rx_buf == {$past(link_shift[0]), $past(link_shift[8:1])};
  endproperty
  a_rx_plain: assert property (p_rx_plain) else $error("plain layout wrong");

  property p_rx_split;
    rise && bit_count == 4'h7 && !cfg_in.clock_phase_delay && cfg_in.rx_bit_arrangement_sel
      |=> evt.rx_update && rx_buf == {$past(link_shift[0]), 1'b0, $past(link_shift[7:1])};
  endproperty
  a_rx_split: assert property (p_rx_split) else $error("split layout wrong");

  property p_clock_phase_delay_first;
    rise && bit_count == 4'h7 && cfg_in.clock_phase_delay
      |=> evt.rx_update && rx_buf[8] == 1'b0 && rx_buf[7:0] == $past(link_shift[7:0]);
  endproperty
  a_clock_phase_delay_first: assert property (p_clock_phase_delay_first) else $error("first transfer missing");

  property p_ack_event;
    rise && bit_count == 4'h8 && !cfg_in.rx_bit_arrangement_sel
      |=> (evt.ack != evt.nack) && evt.nack == $past(link_shift[0]);
  endproperty
  a_ack_event: assert property (p_ack_event) else $error("ack or nack wrong");

  property p_dma_ack;
    evt.dma |-> evt.ack && $past(cfg_in.dma_on_rx_or_ack);
  endproperty
  a_dma_ack: assert property (p_dma_ack) else $error("dma without ack");

  property p_start_wait;
    start && cfg_in.start_detect_init_enable |=> wait_after_eighth_bit && bit_count == 4'h0;
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("start did not set wait");

  property p_start_flag;
    start && cfg_in.start_detect_init_enable && !transmit_buffer_write_in |=> $stable(tx_empty);
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("empty flag moved on start");

  property p_ninth_hold;
    fall && bit_count == 4'h9 && wait_after_eighth_bit |=> scl_hold;
  endproperty
  a_ninth_hold: assert property (p_ninth_hold) else $error("scl not held at ninth fall");

  c_start: cover property (evt.start);
  c_ack: cover property (evt.ack);
  c_nack: cover property (evt.nack);
  c_twice: cover property (evt.rx_update && cfg_in.clock_phase_delay ##[1:400] evt.rx_update);

endmodule

// File: design/isd_pkg.sv
// constants and carriers for the serial-data path of the i2c channel
// assumes a 20 mhz system clock that also serves as the baud count source
package isd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_HZ     = 20_000_000;
  localparam int         CLK_NS     = 1_000_000_000 / CLK_HZ;
  // delay code n (n > 0) holds the data change n + 1 count-source cycles
  localparam logic [3:0] DELAY_EXTRA = 4'h1;
  localparam logic [2:0] DELAY_OFF   = 3'h0;

  // ----------------------------------------------------------------
  // slot positions and buffer layout
  // ----------------------------------------------------------------
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_DATA  = 4'h8;
  localparam logic [3:0] SLOT_ACK   = 4'h9;
  localparam int         RB_ACK_POS = 8;
  localparam logic [8:0] RB_RESET   = 9'h000;
  localparam logic [8:0] TX_IDLE    = 9'h1ff;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sda_delay_select;
    logic       rx_bit_arrangement_sel;
    logic       clock_phase_delay;
    logic       condition_generator_select;
    logic       ack_output_enable;
    logic       ack_data_value;
    logic       start_detect_init_enable;
    logic       dma_on_rx_or_ack;
  } isd_cfg_s;

  typedef struct packed {
    logic rx_update;
    logic ack;
    logic nack;
    logic dma;
    logic start;
  } isd_evt_s;

endpackage

// File: tb/isd_bus_master.sv
// far-side bus master model: makes scl and sda, samples what the device sends
// assumes the bench resolves both open-drain wires with pull-ups
module isd_bus_master (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rel_out,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // bus timing
  // ----------------------------------------------------------------
  // scl stands still outside frames; odd half-times keep it off the system grid
  localparam int TL = 507;
  localparam int TH = 253;

  initial
  begin
    scl_rel_out = 1'b1;
    sda_oe_out  = 1'b0;
  end

  // ----------------------------------------------------------------
  // conditions and pulses
  // ----------------------------------------------------------------
  task automatic start_cond();
    sda_oe_out = 1'b0;
    #(TL);
    scl_rel_out = 1'b1;
    #(TH);
    sda_oe_out = 1'b1;
    #(TH);
    scl_rel_out = 1'b0;
  endtask

  task automatic stop_cond();
    sda_oe_out = 1'b1;
    #(TL);
    scl_rel_out = 1'b1;
    #(TH);
    sda_oe_out = 1'b0;
  endtask

  // bounded wait while the device stretches scl low
  task automatic bit_cyc(input logic b, output logic got);
    #(TL);
    sda_oe_out = ~b;
    #(TL);
    scl_rel_out = 1'b1;
    for (int n = 0; n < 200 && scl_in !== 1'b1; n++)
      #10;
    #(TH);
    got = sda_in;
    #(TH);
    scl_rel_out = 1'b0;
  endtask

  task automatic byte_cyc(input logic [8:0] tx, input int nb, output logic [8:0] rx);
    rx = 9'h1ff;
    for (int i = 8; i > 8 - nb; i--)
      bit_cyc(tx[i], rx[i]);
  endtask
endmodule

// File: tb/isd_sda_path_test.sv
// self-checking bench for the i2c serial-data path
// assumes the master model on the far side; open-drain wires resolved here
module isd_sda_path_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock_in;
  logic              reset_n_in;
  isd_pkg::isd_cfg_s cfg;
  logic [8:0]        tx_buf;
  logic              tx_wr;
  logic              wait_clr;
  logic              sda_oe;
  logic              sda_o, scl_o;
  logic              scl_oe;
  logic [8:0]        rx_buf;
  isd_pkg::isd_evt_s evt;
  logic              empty;
  logic              wait_flag;
  logic              m_scl;
  logic              m_sda;
  wire logic         scl_w;
  wire logic         sda_w;
  logic              scl_d;
  logic              oe_d;
  logic [8:0]        got;
  int                n_mismatch, num_checks, n_ack, n_nack, n_dma, n_upd, n_start, since_fall, lat;

  assign scl_w = m_scl & (scl_oe ? scl_o : 1'b1);
  assign sda_w = ~m_sda & (sda_oe ? sda_o : 1'b1);

  isd_sda_path DUT (
    .clock_in                      (clock_in),
    .reset_n_in                    (reset_n_in),
    .scl_clk_in                    (scl_w),
    .serial_data_pin_in            (sda_w),
    .cfg_in                        (cfg),
    .transmit_buffer_in            (tx_buf),
    .transmit_buffer_write_in      (tx_wr),
    .wait_clear_in                 (wait_clr),
    .serial_data_pin_out           (sda_o),
    .serial_data_pin_oe_out        (sda_oe),
    .serial_clock_pin_out          (scl_o),
    .serial_clock_pin_oe_out       (scl_oe),
    .receive_buffer_out            (rx_buf),
    .events_out                    (evt),
    .transmit_buffer_empty_flag_out(empty),
    .wait_after_eighth_bit_out     (wait_flag)
  );

  isd_bus_master partner (
    .scl_in     (scl_w),
    .sda_in     (sda_w),
    .scl_rel_out(m_scl),
    .sda_oe_out (m_sda)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // ----------------------------------------------------------------
  // shared checking
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic check(input logic [8:0] g, input logic [8:0] e, input string m);
    num_checks++;
    if (g !== e)
      fail($sformatf("%s got %h expected %h", m, g, e));
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // event tally, latency from the last scl fall, data changes under a high clock
  always @(posedge clock_in)
  begin
    n_ack   += int'(evt.ack === 1'b1);
    n_nack  += int'(evt.nack === 1'b1);
    n_dma   += int'(evt.dma === 1'b1);
    n_upd   += int'(evt.rx_update === 1'b1);
    n_start += int'(evt.start === 1'b1);
    since_fall = (scl_d && !scl_w) ? 0 : since_fall + 1;
    if (sda_oe !== oe_d)
    begin
      lat = since_fall;
      if (scl_d && scl_w)
        fail("data changed while clock high");
    end
    scl_d = scl_w;
    oe_d  = sda_oe;
  end

  // ack value fixed at 1, start reinit and ack dma always on
  function automatic isd_pkg::isd_cfg_s mk(input logic [2:0] d, input logic a, input logic c, input logic o);
    return {d, a, c, 1'b0, o, 1'b1, 2'h3};
  endfunction

  // one framed byte; pre > 0 first sends a broken byte of pre bits
  task automatic run_byte(input isd_pkg::isd_cfg_s c, input logic [8:0] b, input logic [8:0] tx, input int pre);
    logic [8:0] junk;
    @(posedge clock_in);
    cfg    <= c;
    tx_buf <= b;
    tx_wr  <= 1'b1;
    @(posedge clock_in);
    tx_wr  <= 1'b0;
    #7;
    {n_ack, n_nack, n_dma, n_upd, n_start} = '0;
    if (pre > 0)
    begin
      partner.start_cond();
      partner.byte_cyc(9'h000, pre, junk);
    end
    partner.start_cond();
    repeat (4) @(posedge clock_in);
    check({7'h00, wait_flag, empty}, 9'h002, "start sets wait, keeps empty");
    check({8'h00, sda_oe}, 9'h000, "level kept after start");
    partner.byte_cyc(tx, 9, got);
    repeat (6) @(posedge clock_in);
    check({8'h00, scl_oe}, 9'h001, "scl held after ninth");
    cfg.ack_output_enable <= 1'b0;
    wait_clr <= 1'b1;
    @(posedge clock_in);
    wait_clr <= 1'b0;
    repeat (6) @(posedge clock_in);
    check({8'h00, scl_oe}, 9'h000, "scl released");
    partner.stop_cond();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({scl_oe, sda_oe, wait_flag, empty, 5'h00}, 9'h020, "reset pins and flags");
    check(rx_buf, isd_pkg::RB_RESET, "reset receive buffer");
  endtask

  task automatic t_rx_ack();
    run_byte(mk(3'h0, 1'b0, 1'b0, 1'b0), 9'h0ff, 9'h14b, 0);
    check(got, 9'h14a, "data released, ack driven");
    check(rx_buf, 9'h0a5, "plain layout");
    check(9'(n_ack * 16 + n_nack), 9'h010, "ack event");
    check(9'(n_dma), 9'h001, "dma on ack");
  endtask

  task automatic t_rx_nack();
    run_byte(mk(3'h0, 1'b0, 1'b0, 1'b0), 9'h1ff, 9'h079, 0);
    check(got, 9'h079, "nack slot released");
    check(rx_buf, 9'h13c, "nack in bit 8");
    check(9'(n_ack * 16 + n_nack + n_dma * 4), 9'h001, "nack event, no dma");
  endtask

  task automatic t_layouts();
    run_byte(mk(3'h0, 1'b1, 1'b0, 1'b0), 9'h0ff, 9'h14b, 0);
    check(rx_buf, 9'h152, "split layout");
    run_byte(mk(3'h0, 1'b1, 1'b1, 1'b0), 9'h0ff, 9'h14b, 0);
    check(rx_buf, 9'h0a5, "phase delay forces plain");
    check(9'(n_upd), 9'h002, "two transfers");
  endtask

  task automatic t_tx_override_restart();
    run_byte(mk(3'h0, 1'b0, 1'b0, 1'b0), 9'h1aa, 9'h1ff, 0);
    check(got, 9'h155, "msb first then bit 8");
    run_byte(mk(3'h0, 1'b0, 1'b0, 1'b1), 9'h0ff, 9'h1ff, 0);
    check(got, 9'h1ff, "ack value overrides");
    run_byte(mk(3'h0, 1'b0, 1'b0, 1'b0), 9'h0ff, 9'h12d, 4);
    check(rx_buf, 9'h096, "restart mid byte");
    check(9'(n_start), 9'h002, "each start reinitialises");
  endtask

  task automatic t_delay();
    int base;
    for (int n = 0; n < 8; n++)
    begin
      run_byte(mk(3'(n), 1'b0, 1'b0, 1'b0), 9'h1aa, 9'h1ff, 0);
      if (n == 0)
        base = lat;
      else
        check(9'(lat - base), 9'(n + 1), "data delay");
    end
  endtask

  initial
  begin
    reset_n_in = 1'b0;
    cfg        = '0;
    tx_buf     = isd_pkg::TX_IDLE;
    tx_wr      = 1'b0;
    wait_clr   = 1'b0;
    scl_d      = 1'b1;
    oe_d       = 1'b0;
    {n_mismatch, num_checks, n_ack, n_nack, n_dma, n_upd, n_start, since_fall, lat} = '0;
    repeat (8) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    t_reset();
    t_rx_ack();
    t_rx_nack();
    t_layouts();
    t_tx_override_restart();
    t_delay();
    report_and_stop();
  end

  // fifteen frames of about 16 us each fit well inside this span
  initial
  begin
    #2_000_000;
    fail("watchdog expired");
    report_and_stop();
  end
endmodule
